// File: verilog/pwrmon_pkg.sv
// constants, types and helpers shared by the power monitor register logic
`default_nettype none
package pwrmon_pkg;
   // register pointer addresses
   localparam logic [7:0] ADDR_CONFIG  = 8'h00;
   localparam logic [7:0] ADDR_CURRENT = 8'h01;
   localparam logic [7:0] ADDR_BUS     = 8'h02;
   // configuration word field positions
   localparam int unsigned CFG_RST_BIT = 15;
   localparam int unsigned CFG_FIX_HI  = 14;
   localparam int unsigned CFG_FIX_LO  = 12;
   localparam int unsigned AVG_HI      = 11;
   localparam int unsigned AVG_LO      = 9;
   localparam int unsigned VCT_HI      = 8;
   localparam int unsigned VCT_LO      = 6;
   localparam int unsigned ICT_HI      = 5;
   localparam int unsigned ICT_LO      = 3;
   localparam int unsigned MODE_HI     = 2;
   localparam int unsigned MODE_LO     = 0;
   // mode bit meanings
   localparam int unsigned MODE_SHUNT_BIT = 0;
   localparam int unsigned MODE_BUS_BIT   = 1;
   localparam int unsigned MODE_CONT_BIT  = 2;
   // reset values of the fields
   localparam logic [2:0]  CFG_FIXED  = 3'h6;
   localparam logic [2:0]  AVG_RESET  = 3'h0;
   localparam logic [2:0]  CT_RESET   = 3'h4;
   localparam logic [2:0]  MODE_RESET = 3'h7;
   localparam logic [11:0] CFG_RESET  = {AVG_RESET, CT_RESET, CT_RESET, MODE_RESET};
   // result scaling: one step is 1250 uA or 1250 uV, full code 7fff
   localparam int unsigned CURRENT_LSB_UA = 1250;
   localparam int unsigned BUS_LSB_UV     = 1250;
   localparam logic [15:0] BUS_FULL_CODE  = 16'h7fff;
   // timing: conversion times are counted in 1 us ticks
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned TICK_NS       = 1000;
   localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
   localparam int unsigned TICK_W        = 16;
   localparam int unsigned TIMER_W       = 14;
   localparam logic [TIMER_W-1:0] TIMER_LAST = 14'h0001;
   localparam logic [TIMER_W-1:0] CONV_US [8] = '{14'd140, 14'd204, 14'd332, 14'd588,
                                                  14'd1100, 14'd2116, 14'd4156, 14'd8244};
   // averaging: 1,4,16,64,128,256,512,1024 samples as shifts
   localparam int unsigned MAX_SHIFT = 10;
   localparam int unsigned SHIFT_W   = 4;
   localparam logic [SHIFT_W-1:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};
   // sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_SHUNT  = 4'h2,
      ST_BUS    = 4'h4,
      ST_FINISH = 4'h8
   } seq_state_t;
   // conversion time code to microseconds
   function automatic logic [TIMER_W-1:0] conv_us(input logic [2:0] code);
      return CONV_US[code];
   endfunction : conv_us
endpackage : pwrmon_pkg
`default_nettype wire

// File: verilog/avg_if.sv
// carrier between the sequencer and one channel averager
`timescale 1ns/100ps
`default_nettype none
interface avg_if #(
   parameter int unsigned W       = 16,
   parameter int unsigned SHIFT_W = 4
);
   logic                clear;        // drop partial sums
   logic                sample_valid; // one new sample
   logic signed [W-1:0] sample;       // sample value
   logic [SHIFT_W-1:0]  shift;        // log2 of sample count
   logic signed [W-1:0] result;       // averaged value
   logic                result_valid; // pulse with result
   modport seq (output clear, sample_valid, sample, shift, input result, result_valid);
   modport avg (input clear, sample_valid, sample, shift, output result, result_valid);
endinterface : avg_if
`default_nettype wire

// File: verilog/conv_averager.sv
// sums a power-of-two number of samples and emits their mean
`timescale 1ns/100ps
`default_nettype none
module conv_averager #(
   parameter int unsigned W         = 16,
   parameter int unsigned MAX_SHIFT = 10
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   avg_if.avg       port
);
   localparam int unsigned AW = W + MAX_SHIFT;
   localparam int unsigned CW = MAX_SHIFT + 1;

   logic signed [AW-1:0] acc_q;   // running sum
   logic signed [AW-1:0] acc_d;   // sum with new sample
   logic [CW-1:0]        cnt_q;   // samples summed
   logic [CW-1:0]        cnt_d;   // count with new sample
   logic [CW-1:0]        target;  // samples per average

   // sign-extending the sample keeps negative currents right
   always_comb begin
      acc_d  = acc_q + AW'(port.sample);
      cnt_d  = cnt_q + CW'(1);
      target = CW'(1) << port.shift;
   end

   // accumulate, then divide by shifting; arithmetic shift keeps sign
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || port.clear) begin
         acc_q             <= '0;
         cnt_q             <= '0;
         port.result_valid <= 1'b0;
         if (!rst_n_in) begin
            port.result <= '0;
         end
      end else begin
         port.result_valid <= 1'b0;
         if (port.sample_valid) begin
            if (cnt_d == target) begin
               port.result       <= W'(acc_d >>> port.shift);
               port.result_valid <= 1'b1;
               acc_q             <= '0;
               cnt_q             <= '0;
            end else begin
               acc_q <= acc_d;
               cnt_q <= cnt_d;
            end
         end
      end
   end

   // result only after exactly the chosen number of samples
   chk_avg_target : assert property (@(posedge clk_in) disable iff (!rst_n_in || port.clear)
      port.sample_valid && cnt_d != target |=> !port.result_valid)
      else $error("average emitted before the sample count was reached");
endmodule : conv_averager
`default_nettype wire

// File: verilog/pwrmon_regs.sv
// configuration, conversion sequencing and result registers of the monitor
// Functional notes
// - writing one to bit 15 resets everything
// - soft reset restores defaults, bit reads zero
// - averaging field picks 1 to 1024 samples
// - bus conversion time from bits 8..6
// - shunt conversion time from bits 5..3
// - mode 000 or 100 is power-down
// - modes 001..011 trigger a single measurement
// - modes 101..111 measure continuously
// - mode resets to 111, continuous both
// - reset: one sample, both times 1.1 ms
// - current result is signed two's complement
// - current step is 1.25 mA
// - results hold averaged values
// - bus result holds latest bus average
// - bus step 1.25 mV, 7fff full scale
// - bus result bit 15 reads zero
// - config write halts and restarts conversion
// - config reads disturb nothing
`timescale 1ns/100ps
`default_nettype none
module pwrmon_regs #(
   parameter int unsigned TICK_CYCLES = pwrmon_pkg::TICK_CYCLES
) (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   output logic      [15:0] reg_rdata_out,
   input  wire logic [15:0] current_sample_in,
   input  wire logic [14:0] bus_sample_in,
   output logic             conv_ready_out,
   output logic             conv_active_out
);
   localparam int unsigned RW = pwrmon_pkg::MAX_SHIFT + 1;

   logic                               soft_rst_q;    // self-clearing reset pulse
   logic                               sys_rst;       // pin or soft reset
   logic                               cfg_wr;        // config write this cycle
   logic [11:0]                        cfg_q;         // writable config bits
   logic [2:0]                         mode;          // operating mode field
   logic [2:0]                         vct;           // bus conversion code
   logic [2:0]                         ict;           // shunt conversion code
   logic [2:0]                         avg;           // averaging code
   logic                               shunt_en;      // mode measures current
   logic                               bus_en;        // mode measures voltage
   logic                               cont;          // mode repeats
   logic [pwrmon_pkg::TICK_W-1:0]      tick_cnt_q;    // 1 us divider
   logic                               tick_q;        // 1 us enable pulse
   pwrmon_pkg::seq_state_t             state_q;       // sequencer state
   logic                               pending_q;     // conversion requested
   logic [pwrmon_pkg::TIMER_W-1:0]     timer_q;       // us left in conversion
   logic                               timer_done;    // last us of conversion
   logic [RW-1:0]                      round_q;       // rounds taken
   logic [RW-1:0]                      rounds;        // rounds per average
   pwrmon_pkg::seq_state_t             first_state;   // first channel of round
   logic [pwrmon_pkg::TIMER_W-1:0]     first_time;    // its conversion time
   logic [15:0]                        current_q;     // current result
   logic [15:0]                        bus_q;         // bus voltage result

   avg_if #(.W(16), .SHIFT_W(pwrmon_pkg::SHIFT_W)) ch_if[2] ();

   // software reset runs one cycle then clears itself; only the pin resets it
   // the !soft_rst_q term stops a strobe held over the pulse from retriggering it
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= cfg_wr && reg_wdata_in[pwrmon_pkg::CFG_RST_BIT] && !soft_rst_q;
      end
   end

   // field decode of the stored configuration
   // the fixed pattern of bits 14..12 is never stored, only rebuilt on read
   always_comb begin
      sys_rst  = !rst_n_in || soft_rst_q;
      cfg_wr   = reg_wr_in && reg_addr_in == pwrmon_pkg::ADDR_CONFIG;
      mode     = cfg_q[pwrmon_pkg::MODE_HI:pwrmon_pkg::MODE_LO];
      ict      = cfg_q[pwrmon_pkg::ICT_HI:pwrmon_pkg::ICT_LO];
      vct      = cfg_q[pwrmon_pkg::VCT_HI:pwrmon_pkg::VCT_LO];
      avg      = cfg_q[pwrmon_pkg::AVG_HI:pwrmon_pkg::AVG_LO];
      // 000 and 100 enable neither channel, so nothing converts
      shunt_en = mode[pwrmon_pkg::MODE_SHUNT_BIT];
      bus_en   = mode[pwrmon_pkg::MODE_BUS_BIT];
      cont     = mode[pwrmon_pkg::MODE_CONT_BIT];
      rounds   = RW'(1) << pwrmon_pkg::AVG_SHIFT[avg];
      timer_done = tick_q && timer_q == pwrmon_pkg::TIMER_LAST;
      // shunt goes first when both channels are on
      if (shunt_en) begin
         first_state = pwrmon_pkg::ST_SHUNT;
         first_time  = pwrmon_pkg::conv_us(ict);
      end else begin
         first_state = pwrmon_pkg::ST_BUS;
         first_time  = pwrmon_pkg::conv_us(vct);
      end
   end

   // configuration store; a write with the reset bit set stores nothing
   // trade-off: storing only 12 bits keeps bit 15 from ever reading one
   always_ff @(posedge clk_in) begin
      if (sys_rst) begin
         cfg_q <= pwrmon_pkg::CFG_RESET;
      end else if (cfg_wr && !reg_wdata_in[pwrmon_pkg::CFG_RST_BIT]) begin
         cfg_q <= reg_wdata_in[pwrmon_pkg::AVG_HI:0]; // bits 14..12 dropped
      end
   end

   // 1 us enable; restarted by a config write so timing starts afresh
   // limitation: conversion times are only as exact as TICK_CYCLES
   always_ff @(posedge clk_in) begin
      if (sys_rst || cfg_wr) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == pwrmon_pkg::TICK_W'(TICK_CYCLES - 1)) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + pwrmon_pkg::TICK_W'(1);
         tick_q     <= 1'b0;
      end
   end

   // conversion sequencer: shunt then bus per round, rounds per average
   // one timer serves both channels, so their conversions never overlap
   always_ff @(posedge clk_in) begin
      if (sys_rst || cfg_wr) begin
         // a write aborts the running conversion and requests a new one
         state_q   <= pwrmon_pkg::ST_IDLE;
         pending_q <= 1'b1;
         timer_q   <= '0;
         round_q   <= '0;
      end else begin
         case (state_q)
            pwrmon_pkg::ST_IDLE: begin
               // power-down leaves the request parked
               if (pending_q && (shunt_en || bus_en)) begin
                  pending_q <= 1'b0;
                  state_q   <= first_state;
                  timer_q   <= first_time;
               end
            end
            pwrmon_pkg::ST_SHUNT, pwrmon_pkg::ST_BUS: begin
               if (tick_q) begin
                  timer_q <= timer_q - pwrmon_pkg::TIMER_W'(1);
               end
               if (timer_done) begin
                  if (state_q == pwrmon_pkg::ST_SHUNT && bus_en) begin
                     state_q <= pwrmon_pkg::ST_BUS;
                     timer_q <= pwrmon_pkg::conv_us(vct);
                  end else if (round_q + RW'(1) == rounds) begin
                     state_q <= pwrmon_pkg::ST_FINISH;
                     round_q <= '0;
                  end else begin
                     round_q <= round_q + RW'(1);
                     state_q <= first_state;
                     timer_q <= first_time;
                  end
               end
            end
            pwrmon_pkg::ST_FINISH: begin
               // triggered modes stop here, continuous ones go again
               state_q   <= pwrmon_pkg::ST_IDLE;
               pending_q <= cont;
            end
            default: begin
               state_q <= pwrmon_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // status outputs, registered
   // both lag the sequencer by one cycle since they come from its state
   always_ff @(posedge clk_in) begin
      if (sys_rst) begin
         conv_ready_out  <= 1'b0;
         conv_active_out <= 1'b0;
      end else begin
         conv_ready_out  <= state_q == pwrmon_pkg::ST_FINISH;
         conv_active_out <= state_q != pwrmon_pkg::ST_IDLE;
      end
   end

   // channel averagers: 0 is shunt current, 1 is bus voltage
   // both share one shift; the round counter keeps their sample counts equal
   for (genvar i = 0; i < 2; i++) begin : g_ch
      assign ch_if[i].clear        = sys_rst || cfg_wr;
      assign ch_if[i].shift        = pwrmon_pkg::AVG_SHIFT[avg];
      assign ch_if[i].sample_valid = timer_done &&
         state_q == (i == 0 ? pwrmon_pkg::ST_SHUNT : pwrmon_pkg::ST_BUS);
      // front end delivers codes already at 1.25 mA and 1.25 mV per step
      assign ch_if[i].sample = (i == 0) ? current_sample_in : {1'b0, bus_sample_in};
      conv_averager #(.W(16), .MAX_SHIFT(pwrmon_pkg::MAX_SHIFT)) u_avg (
         .clk_in   (clk_in),
         .rst_n_in (!sys_rst),
         .port     (ch_if[i])
      );
   end

   // result words load only when an average completes
   // a host read mid-average still sees the previous complete result
   always_ff @(posedge clk_in) begin
      if (sys_rst) begin
         current_q <= '0;
         bus_q     <= '0;
      end else begin
         if (ch_if[0].result_valid) begin
            current_q <= ch_if[0].result; // signed
         end
         if (ch_if[1].result_valid) begin
            bus_q <= {1'b0, ch_if[1].result[14:0]};
         end
      end
   end

   // read port; a read changes nothing but the read data
   // read data holds until the next read, so a slow host can fetch it late
   always_ff @(posedge clk_in) begin
      if (sys_rst) begin
         reg_rdata_out <= '0;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            pwrmon_pkg::ADDR_CONFIG:  reg_rdata_out <= {1'b0, pwrmon_pkg::CFG_FIXED, cfg_q};
            pwrmon_pkg::ADDR_CURRENT: reg_rdata_out <= current_q;
            pwrmon_pkg::ADDR_BUS:     reg_rdata_out <= bus_q;
            default:                  reg_rdata_out <= '0; // unmapped reads zero
         endcase
      end
   end

   // rule checks; both resets park them through the default disable, except chk_soft_reset and chk_soft_clear, which only the pin parks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst);

   chk_soft_reset : assert property (disable iff (!rst_n_in)
      cfg_wr && reg_wdata_in[pwrmon_pkg::CFG_RST_BIT] && !soft_rst_q
      |=> soft_rst_q ##1 cfg_q == pwrmon_pkg::CFG_RESET && state_q == pwrmon_pkg::ST_IDLE && !soft_rst_q)
      else $error("soft reset did not restore defaults");
   chk_rst_readback : assert property (reg_rd_in && reg_addr_in == pwrmon_pkg::ADDR_CONFIG
      |=> !reg_rdata_out[pwrmon_pkg::CFG_RST_BIT])
      else $error("reset bit read back as one");
   chk_fixed_bits : assert property (reg_rd_in && reg_addr_in == pwrmon_pkg::ADDR_CONFIG
      |=> reg_rdata_out[pwrmon_pkg::CFG_FIX_HI:pwrmon_pkg::CFG_FIX_LO] == pwrmon_pkg::CFG_FIXED)
      else $error("fixed config bits wrong");
   chk_power_down : assert property (state_q == pwrmon_pkg::ST_IDLE && !shunt_en && !bus_en
      |=> state_q == pwrmon_pkg::ST_IDLE)
      else $error("conversion started in power-down");
   chk_trig_stop : assert property (state_q == pwrmon_pkg::ST_FINISH && !cont && !cfg_wr
      |=> state_q == pwrmon_pkg::ST_IDLE && !pending_q)
      else $error("triggered mode did not stop");
   chk_cont_repeat : assert property (state_q == pwrmon_pkg::ST_FINISH && cont && !cfg_wr
      |=> pending_q ##1 ($past(cfg_wr) || state_q != pwrmon_pkg::ST_IDLE))
      else $error("continuous mode did not restart");
   chk_mode_default : assert property ($rose(rst_n_in) |-> mode == pwrmon_pkg::MODE_RESET)
      else $error("mode default wrong");
   chk_time_default : assert property ($rose(rst_n_in)
      |-> avg == pwrmon_pkg::AVG_RESET && vct == pwrmon_pkg::CT_RESET && ict == pwrmon_pkg::CT_RESET)
      else $error("averaging or time default wrong");
   chk_bus_load : assert property (ch_if[1].result_valid
      |=> bus_q == {1'b0, $past(ch_if[1].result[14:0])})
      else $error("bus result not loaded");
   chk_bus_sign : assert property (reg_rd_in && reg_addr_in == pwrmon_pkg::ADDR_BUS
      |=> !reg_rdata_out[15])
      else $error("bus result bit 15 set");
   chk_write_halt : assert property (cfg_wr |=> state_q == pwrmon_pkg::ST_IDLE && pending_q)
      else $error("config write did not halt conversion");
   chk_read_quiet : assert property (reg_rd_in && !reg_wr_in && !timer_done
      && (state_q == pwrmon_pkg::ST_SHUNT || state_q == pwrmon_pkg::ST_BUS)
      |=> $stable(cfg_q) && $stable(state_q))
      else $error("read disturbed configuration");

   // sequencing and result checks
   chk_shunt_time : assert property (state_q == pwrmon_pkg::ST_IDLE && pending_q && shunt_en && !cfg_wr
      |=> state_q == pwrmon_pkg::ST_SHUNT && timer_q == pwrmon_pkg::conv_us(ict))
      else $error("shunt conversion time not loaded");
   chk_bus_time : assert property (state_q == pwrmon_pkg::ST_SHUNT && timer_done && bus_en && !cfg_wr
      |=> state_q == pwrmon_pkg::ST_BUS && timer_q == pwrmon_pkg::conv_us(vct))
      else $error("bus conversion time not loaded");
   chk_bus_first : assert property (
      state_q == pwrmon_pkg::ST_IDLE && pending_q && bus_en && !shunt_en && !cfg_wr
      |=> state_q == pwrmon_pkg::ST_BUS && timer_q == pwrmon_pkg::conv_us(vct))
      else $error("bus-only conversion did not start");
   chk_current_load : assert property (ch_if[0].result_valid |=> current_q == $past(ch_if[0].result))
      else $error("current result not loaded");
   chk_round_limit : assert property (
      (state_q == pwrmon_pkg::ST_SHUNT || state_q == pwrmon_pkg::ST_BUS) |-> round_q < rounds)
      else $error("more rounds than the averaging count");
   chk_soft_clear : assert property (disable iff (!rst_n_in) soft_rst_q |=> !soft_rst_q)
      else $error("soft reset bit did not clear");
   chk_channel_select : assert property (
      (!ch_if[0].sample_valid || shunt_en) && (!ch_if[1].sample_valid || bus_en))
      else $error("sample taken from a channel the mode leaves off");
   chk_ready_pulse : assert property (conv_ready_out |=> !conv_ready_out)
      else $error("conversion ready held longer than one cycle");

   cov_soft_reset : cover property (soft_rst_q);
   cov_trig_done  : cover property (state_q == pwrmon_pkg::ST_FINISH && !cont);
   cov_neg_result : cover property (ch_if[0].result_valid && ch_if[0].result[15]);
   cov_cfg_abort  : cover property (cfg_wr && state_q != pwrmon_pkg::ST_IDLE);
   cov_cont_again : cover property (state_q == pwrmon_pkg::ST_FINISH && cont);
endmodule : pwrmon_regs
`default_nettype wire

// File: bench/front_end_model.sv
// front-end sample source standing in for the shunt and bus converters
`timescale 1ns/100ps
`default_nettype none
module front_end_model (
   input  wire logic        clk_in,             // system clock
   input  wire logic        conv_active_in,     // sequencer busy
   input  wire logic [15:0] current_set_in,     // current the bench wants seen
   input  wire logic [14:0] bus_set_in,         // bus voltage the bench wants seen
   output logic      [15:0] current_sample_out, // current sample to the block
   output logic      [14:0] bus_sample_out      // bus sample to the block
);
   logic flip_q = 1'b0; // scrambles the lines while idle

   // idle lines change every cycle, so a sample taken outside a conversion
   // shows up as a wrong result instead of matching by luck
   always_ff @(posedge clk_in) begin
      flip_q             <= ~flip_q;
      current_sample_out <= current_set_in ^ {16{~conv_active_in & flip_q}};
      bus_sample_out     <= bus_set_in ^ {15{~conv_active_in & ~flip_q}};
   end
endmodule : front_end_model
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the power monitor register block
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        clk_in;          // 100 MHz clock
   logic        rst_n_in;        // synchronous reset, active low
   logic        reg_wr_in;       // write strobe
   logic        reg_rd_in;       // read strobe
   logic [7:0]  reg_addr_in;     // register pointer
   logic [15:0] reg_wdata_in;    // write data
   logic [15:0] reg_rdata_out;   // read data
   logic [15:0] current_sample_in;
   logic [14:0] bus_sample_in;
   logic        conv_ready_out;  // average complete pulse
   logic        conv_active_out; // sequencer busy
   logic [15:0] cur_set;         // current presented by the front end
   logic [14:0] bus_set;         // bus voltage presented by the front end
   int          err_count;
   int          checks_done;

   // short ticks keep the 140 us conversions a few hundred cycles long
   pwrmon_regs #(.TICK_CYCLES(2)) u_pwrmon_regs (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
      .current_sample_in(current_sample_in), .bus_sample_in(bus_sample_in),
      .conv_ready_out(conv_ready_out), .conv_active_out(conv_active_out));
   front_end_model u_front_end_model (.clk_in(clk_in), .conv_active_in(conv_active_out),
      .current_set_in(cur_set), .bus_set_in(bus_set),
      .current_sample_out(current_sample_in), .bus_sample_out(bus_sample_in));

   // clock generation
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic complete_run;
      if (err_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // one write; the extra cycle covers the dead edge after a soft reset
   task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
      @(negedge clk_in);
      reg_wr_in    = 1'b1;
      reg_addr_in  = addr;
      reg_wdata_in = data;
      @(negedge clk_in);
      reg_wr_in = 1'b0;
      @(negedge clk_in);
   endtask : write_reg

   // read data stands from the edge after the strobe
   task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
      @(negedge clk_in);
      reg_rd_in   = 1'b1;
      reg_addr_in = addr;
      @(negedge clk_in);
      reg_rd_in = 1'b0;
      data      = reg_rdata_out;
   endtask : read_reg

   task automatic wait_ready(input int limit, output int cycles);
      cycles = -1;
      for (int i = 0; i < limit; i++) begin
         @(negedge clk_in);
         if (conv_ready_out === 1'b1) begin
            cycles = i;
            break;
         end
      end
   endtask : wait_ready

   // defaults after power-on reset, unmapped address reads zero
   task automatic t_defaults;
      logic [15:0] v;
      read_reg(8'h00, v);
      check("config default", v, 16'h6127);
      read_reg(8'h01, v);
      check("current default", v, 16'h0000);
      read_reg(8'h02, v);
      check("bus default", v, 16'h0000);
      read_reg(8'h05, v);
      check("unmapped read", v, 16'h0000);
   endtask : t_defaults

   // field storage, fixed bits, read-only current result, soft reset
   task automatic t_fields;
      logic [15:0] v;
      write_reg(8'h00, 16'h7249);
      read_reg(8'h00, v);
      check("config fields", v, 16'h6249);
      write_reg(8'h00, 16'h0db6);
      read_reg(8'h00, v);
      check("config fixed bits", v, 16'h6db6);
      write_reg(8'h01, 16'h5555);
      read_reg(8'h01, v);
      check("current read-only", v, 16'h0000);
      write_reg(8'h00, 16'h8e00);
      read_reg(8'h00, v);
      check("config after soft reset", v, 16'h6127);
   endtask : t_fields

   // both power-down codes must keep the sequencer idle
   task automatic t_powerdown;
      int busy;
      for (int m = 0; m < 8; m += 4) begin
         write_reg(8'h00, 16'(m));
         busy = 0;
         repeat (600) @(negedge clk_in) busy += (conv_active_out !== 1'b0);
         check("power-down idle", 16'(busy), 16'h0000);
      end
   endtask : t_powerdown

   // every measuring mode: which results move, single-shot or repeating
   task automatic t_modes;
      logic [15:0] v;
      logic [15:0] exp_cur;
      logic [14:0] exp_bus;
      int          n;
      exp_cur = 16'h0000;
      exp_bus = 15'h0000;
      for (int m = 1; m < 8; m++) begin
         if (m == 4) continue;
         write_reg(8'h00, 16'h0200 | 16'(m)); // four samples, shortest times
         cur_set = {1'b1, 15'(m * 16'h0123)};
         bus_set = (m == 7) ? 15'h7fff : 15'(m * 16'h0a5a);
         if (m[0]) exp_cur = cur_set;
         if (m[1]) exp_bus = bus_set;
         read_reg(8'h00, v);
         check("config mid-conversion", v, 16'h6200 | 16'(m));
         wait_ready(5000, n);
         check("first ready", 16'(n >= 0), 16'h0001);
         read_reg(8'h01, v);
         check("current result", v, exp_cur);
         read_reg(8'h02, v);
         check("bus result", v, {1'b0, exp_bus});
         wait_ready(3000, n);
         check("repeat ready", 16'(n >= 0), 16'(m / 4));
      end
   endtask : t_modes

   // a rewrite mid-conversion restarts the full shunt and bus sequence
   task automatic t_restart;
      int          n;
      logic [15:0] v;
      write_reg(8'h00, 16'h0007);
      repeat (200) @(negedge clk_in);
      cur_set = 16'h0042;
      write_reg(8'h00, 16'h0007);
      wait_ready(3000, n);
      check("restart time", 16'(n >= 560), 16'h0001);
      read_reg(8'h01, v);
      check("restart current", v, 16'h0042);
   endtask : t_restart

   // bounded well above the expected run length of roughly 25k cycles
   initial begin
      repeat (60000) @(posedge clk_in);
      err_count++;
      complete_run();
   end

   initial begin
      err_count    = 0;
      checks_done  = 0;
      rst_n_in     = 1'b0;
      reg_wr_in    = 1'b0;
      reg_rd_in    = 1'b0;
      reg_addr_in  = 8'h00;
      reg_wdata_in = 16'h0000;
      cur_set      = 16'h0000;
      bus_set      = 15'h0000;
      repeat (5) @(negedge clk_in);
      rst_n_in = 1'b1;
      t_defaults();
      t_fields();
      t_powerdown();
      t_modes();
      t_restart();
      complete_run();
   end
endmodule : tb
`default_nettype wire
